//--- logic/mem_port_pkg.sv
package mem_port_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int DMA_N = 4;
  localparam int MODULE_BITS = 3;
  localparam int PROTECT_BITS = 7;
  localparam int SYNC_STAGES = 3;
  localparam int CLK_NS = 50;
  localparam int OSC_NS = 60;
  localparam int MEM_OSC_STEPS = 8;
  localparam int ACCESS_NS = 300;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYCLE_NS = OSC_NS * MEM_OSC_STEPS;
  localparam int CYCLE_CYC = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [3:0] CNT_W4 = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_GRANT = 5'b00010,
    ST_START = 5'b00100,
    ST_RUN = 5'b01000,
    ST_END = 5'b10000
  } seq_state_t;

  // Active low shared memory bus, driven while the port owns memory
  typedef struct packed {
    logic [14:0] addr_n;
    logic [15:0] data_n;
    logic read_n;
    logic start_n;
  } mem_bus_t;
endpackage

//--- logic/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pin and clean level
  input wire logic pin_in,
  input wire logic idle_in,
  output logic level_out
);
  import mem_port_pkg::*;

  logic [SYNC_STAGES-1:0] stage_r;

  // Third stage agreeing with second filters single-cycle glitches
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      stage_r <= '0;
      level_out <= 1'b0;
    end
    else
    begin
      stage_r <= {stage_r[SYNC_STAGES-2:0], pin_in};
      if (stage_r[1] == stage_r[2])
        level_out <= stage_r[1];
      else
        level_out <= level_out;
    end
  end

  logic unused_idle;
  assign unused_idle = idle_in;
endmodule

//--- logic/shared_core_memory_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Four DMA devices and the processor share one memory and control.
// - Addresses cover 32K words of 16 bits with no circuit change.
// - Memory data, address and control buses are active low.
// - Master address loads on datapath clock with load control; readable.
// - Slave address follows master while idle, holds while busy.
// - Slave address drives memory bus only with both processor selects.
// - Top three address bits, true and inverted, pick one of eight modules.
// - Top seven slave address bits are exported for memory protection.
// - Without byte swap, the word register loads all 16 source bits.
// - Byte swap loads one byte from the swapped source, other byte kept.
// - Byte select is active when the lowest address bit is clear.
// - Processor read loads the word register from the sense bus.
// - Word register clears on the second clock after a processor read start.
// - DMA request sets grant pending, drops enable, blocks processor start.
// - DMA busy sets on the grant-state clock after grant pending, with the DMA cycle flop.
// - Grant takes next idle cycle: sets DMA cycle, deselects processor.
// - A held DMA request captures consecutive cycles, each through grant.
// - Clock after start sets processor busy and cycle hold flops.
// - Cycle complete fires a one-shot clearing DMA busy and cycle flops.
// - Fourth clock drops hold and processor cycle flop; fifth clears busy; select frees.
// - Processor cycle sets data unavailable for one clock after start.
// - Memory timing steps from the system clock after any start; the oscillator count is not used.
module shared_core_memory_port
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Datapath side
  input wire logic datapath_clock_low_in,
  input wire logic datapath_clock_high_in,
  input wire logic load_address_ctl_in,
  input wire logic byte_swap_request_in,
  input wire logic read_cycle_in,
  input wire logic processor_mem_start_in,
  input wire logic [15:0] source_bus_in,
  output logic [15:0] addr_b_bus_out,
  output logic [15:0] word_b_bus_out,
  output logic processor_busy_ind_out,
  output logic data_unavailable_out,
  output logic byte_select_out,
  // DMA ports, active low
  input wire logic [3:0] dma_request_n_in,
  output logic [3:0] dma_enable_line_n_out,
  // Memory side; sense, bus and module selects active low
  input wire logic [15:0] memory_sense_bus_n_in,
  output mem_port_pkg::mem_bus_t mem_bus_out,
  output logic mem_bus_oe_out,
  output logic [7:0] module_select_n_out,
  output logic [2:0] module_addr_n_out,
  output logic [2:0] module_addr_out,
  output logic [6:0] protect_addr_out,
  output logic memory_busy_out,
  output logic mid_cycle_pulse_out,
  output logic cycle_complete_pulse_out
);
  import mem_port_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic [3:0] req_s;
  logic [14:0] address_master_rank_r;
  logic [14:0] address_slave_rank_r;
  logic [15:0] memory_word_register_r;
  logic [15:0] sense;
  logic [15:0] swapped;
  logic dcl_lo_d_r, dcl_hi_d_r;
  logic dcl_lo_fall, dcl_hi_fall;
  logic [3:0] grant_pending_r;
  logic [1:0] chan_r;
  logic dma_busy_flop_r, dma_cycle_flop_r, dma_cycle_hold_r;
  logic processor_cycle_flop_r, proc_busy_r, processor_select_r;
  logic data_unavailable_r, read_latched_r;
  logic [3:0] clk_after_r;
  logic [3:0] osc_cnt_r;
  seq_state_t state_r;
  logic start_pulse, proc_start, any_pending, cycle_active, oneshot;
  logic processor_memory_busy;

  genvar gi;
  generate
    for (gi = 0; gi < DMA_N; gi++)
    begin : g_sync
      pin_sync u_sync
      (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in(~dma_request_n_in[gi]),
        .idle_in(1'b0),
        .level_out(req_s[gi])
      );
    end
  endgenerate

  assign sense = ~memory_sense_bus_n_in;
  assign swapped = {source_bus_in[7:0], source_bus_in[15:8]};
  assign dcl_lo_fall = dcl_lo_d_r & ~datapath_clock_low_in;
  assign dcl_hi_fall = dcl_hi_d_r & ~datapath_clock_high_in;
  assign any_pending = |grant_pending_r;
  assign cycle_active = state_r != ST_IDLE;
  // Grant pending suppresses a coinciding processor start
  assign proc_start = processor_mem_start_in & ~|req_s
    & ~any_pending & ~cycle_active & processor_select_r;
  assign processor_memory_busy = proc_busy_r | processor_cycle_flop_r;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dcl_lo_d_r <= 1'b0;
      dcl_hi_d_r <= 1'b0;
    end
    else
    begin
      dcl_lo_d_r <= datapath_clock_low_in;
      dcl_hi_d_r <= datapath_clock_high_in;
    end
  end

  // Address ranks
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      address_master_rank_r <= ADDR_RESET;
    else if (dcl_lo_fall && load_address_ctl_in)
      address_master_rank_r <= source_bus_in[14:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      address_slave_rank_r <= ADDR_RESET;
    else if (!memory_busy_out && !processor_memory_busy)
      address_slave_rank_r <= address_master_rank_r;
  end

  assign addr_b_bus_out = {1'b0, address_master_rank_r};
  assign byte_select_out = ~address_master_rank_r[0];
  assign module_addr_out = address_slave_rank_r[14:12];
  assign module_addr_n_out = ~address_slave_rank_r[14:12];
  assign protect_addr_out = address_slave_rank_r[14:8];
  always_comb
  begin
    module_select_n_out = 8'hFF;
    module_select_n_out[address_slave_rank_r[14:12]] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Word register: clear, sense load, datapath load
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      memory_word_register_r <= WORD_RESET;
    else if (data_unavailable_r && read_latched_r
             && clk_after_r == 4'h1)
      memory_word_register_r <= WORD_RESET;
    else if (read_latched_r && processor_select_r == 1'b1
             && processor_cycle_flop_r && clk_after_r >= 4'h2)
      memory_word_register_r <= memory_word_register_r | sense;
    else if (dcl_hi_fall && !byte_swap_request_in)
      memory_word_register_r <= source_bus_in;
    else if (dcl_hi_fall && byte_select_out)
      memory_word_register_r[15:8] <= swapped[15:8];
    else if (dcl_hi_fall)
      memory_word_register_r[7:0] <= swapped[7:0];
  end
  assign word_b_bus_out = memory_word_register_r;

  ////////////////////////////////////////////////////////////////////
  // DMA grant: one pending flop per port, fixed priority lowest index
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      grant_pending_r <= 4'h0;
      chan_r <= 2'd0;
    end
    else if (!any_pending && !cycle_active && processor_select_r)
    begin
      for (int i = DMA_N - 1; i >= 0; i--)
        if (req_s[i])
        begin
          grant_pending_r <= 4'h1 << i;
          chan_r <= 2'(i);
        end
    end
    else if (state_r == ST_GRANT)
      grant_pending_r <= 4'h0;
  end
  assign dma_enable_line_n_out = ~grant_pending_r;

  // Cycle sequencer driven by system clocks; the oscillator count only counts down
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      clk_after_r <= CNT_W4;
      osc_cnt_r <= CNT_W4;
    end
    else
      case (state_r)
        ST_IDLE:
        begin
          clk_after_r <= CNT_W4;
          if (any_pending)
            state_r <= ST_GRANT;
          else if (proc_start)
            state_r <= ST_START;
        end
        ST_GRANT: state_r <= ST_START;
        ST_START:
        begin
          state_r <= ST_RUN;
          osc_cnt_r <= 4'(CYCLE_CYC);
          clk_after_r <= 4'h1;
        end
        ST_RUN:
        begin
          clk_after_r <= clk_after_r + 4'h1;
          if (osc_cnt_r != 4'h0)
            osc_cnt_r <= osc_cnt_r - 4'h1;
          if (clk_after_r == 4'h3)
            state_r <= ST_END;
        end
        ST_END: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
  end

  assign start_pulse = state_r == ST_START;
  assign oneshot = state_r == ST_RUN && clk_after_r == 4'h2;

  // Control flops
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dma_busy_flop_r <= 1'b0;
      dma_cycle_flop_r <= 1'b0;
      dma_cycle_hold_r <= 1'b0;
      processor_cycle_flop_r <= 1'b0;
      proc_busy_r <= 1'b0;
      processor_select_r <= 1'b1;
      data_unavailable_r <= 1'b0;
      read_latched_r <= 1'b0;
    end
    else
    begin
      if (state_r == ST_GRANT)
      begin
        dma_busy_flop_r <= 1'b1;
        dma_cycle_flop_r <= 1'b1;
        processor_select_r <= 1'b0;
      end
      if (state_r == ST_IDLE && proc_start && !any_pending)
      begin
        processor_cycle_flop_r <= 1'b1;
        read_latched_r <= read_cycle_in;
        data_unavailable_r <= 1'b1;
      end
      if (start_pulse)
      begin
        proc_busy_r <= 1'b1;
        dma_cycle_hold_r <= 1'b1;
      end
      if (state_r == ST_RUN && clk_after_r == 4'h1)
        data_unavailable_r <= 1'b0;
      if (oneshot)
      begin
        dma_busy_flop_r <= 1'b0;
        dma_cycle_flop_r <= 1'b0;
      end
      if (state_r == ST_RUN && clk_after_r == 4'h3)
      begin
        dma_cycle_hold_r <= 1'b0;
        processor_cycle_flop_r <= 1'b0;
        read_latched_r <= 1'b0;
      end
      if (state_r == ST_END)
      begin
        proc_busy_r <= 1'b0;
        processor_select_r <= 1'b1;
      end
    end
  end

  assign memory_busy_out = dma_cycle_hold_r | dma_cycle_flop_r
    | processor_cycle_flop_r;
  assign processor_busy_ind_out = any_pending | dma_busy_flop_r
    | proc_busy_r | cycle_active;
  assign data_unavailable_out = data_unavailable_r;
  assign mid_cycle_pulse_out = start_pulse;
  assign cycle_complete_pulse_out = oneshot;

  ////////////////////////////////////////////////////////////////////
  // Processor drives bus only when both selects active
  assign mem_bus_oe_out = processor_select_r & processor_cycle_flop_r;
  always_comb
  begin
    mem_bus_out.addr_n = ~address_slave_rank_r;
    mem_bus_out.data_n = ~memory_word_register_r;
    mem_bus_out.read_n = ~read_latched_r;
    mem_bus_out.start_n = ~start_pulse;
  end

  ////////////////////////////////////////////////////////////////////
  wire [1:0] unused_chan = chan_r;
  default disable iff (rst_in);

  grant_hold_a: assert property (@(posedge clk_in)
    any_pending && state_r == ST_IDLE |=> state_r == ST_GRANT)
    else $error("grant lost");
  dma_start_a: assert property (@(posedge clk_in)
    state_r == ST_GRANT |=> start_pulse && !processor_select_r)
    else $error("dma start");
  slave_hold_a: assert property (@(posedge clk_in)
    memory_busy_out |=> $stable(address_slave_rank_r))
    else $error("slave moved");
  busy_set_a: assert property (@(posedge clk_in)
    start_pulse |=> proc_busy_r && dma_cycle_hold_r)
    else $error("busy not set");
  dua_one_a: assert property (@(posedge clk_in)
    start_pulse && data_unavailable_r |=> ##1 !data_unavailable_r)
    else $error("dua long");
  oneshot_a: assert property (@(posedge clk_in)
    oneshot |=> !dma_busy_flop_r && !dma_cycle_flop_r)
    else $error("oneshot");
  release_a: assert property (@(posedge clk_in)
    start_pulse |-> ##4 state_r == ST_END ##1 processor_select_r)
    else $error("release");
  byte_sel_a: assert property (@(posedge clk_in)
    byte_select_out == !address_master_rank_r[0])
    else $error("byte select");
endmodule

//--- tb/core_mem_model.sv
`timescale 1ns/100ps
module core_mem_model
(
  // Clock
  input wire logic clk_in,
  // Port side
  input wire logic start_pulse_in,
  input wire logic [15:0] rd_data_in,
  output logic [15:0] sense_n_out
);
  int cnt;

  initial
  begin
    cnt = 0;
    sense_n_out = 16'hFFFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout lands between second and third clock after start
  always @(posedge clk_in)
  begin
    if (start_pulse_in)
      cnt <= 1;
    else if (cnt != 0)
      cnt <= (cnt == 4) ? 0 : cnt + 1;
    if (cnt >= 1 && cnt <= 3)
      sense_n_out <= ~rd_data_in;
    else
      sense_n_out <= ~sense_n_out; // Released bus inverts its last value every clock
  end
endmodule

//--- tb/shared_core_memory_port_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module shared_core_memory_port_tb_top;
  import mem_port_pkg::*;
  logic clk_in, rst_in, datapath_clock_low_in, datapath_clock_high_in;
  logic load_address_ctl_in, byte_swap_request_in, read_cycle_in;
  logic processor_mem_start_in, processor_busy_ind_out, data_unavailable_out;
  logic byte_select_out, mem_bus_oe_out, memory_busy_out;
  logic mid_cycle_pulse_out, cycle_complete_pulse_out;
  logic [15:0] source_bus_in, addr_b_bus_out, word_b_bus_out;
  logic [15:0] memory_sense_bus_n_in, rdata, d;
  logic [3:0] dma_request_n_in, dma_enable_line_n_out, req_n;
  logic [7:0] module_select_n_out, sel;
  logic [2:0] module_addr_n_out, module_addr_out;
  logic [6:0] protect_addr_out;
  logic [14:0] a;
  logic [31:0] lfsr_r;
  mem_bus_t mem_bus_out;
  int err_total, checked, exp_word;

  shared_core_memory_port shared_core_memory_port_inst
  (
    .clk_in, .rst_in, .datapath_clock_low_in, .datapath_clock_high_in,
    .load_address_ctl_in, .byte_swap_request_in, .read_cycle_in,
    .processor_mem_start_in, .source_bus_in, .addr_b_bus_out,
    .word_b_bus_out, .processor_busy_ind_out, .data_unavailable_out,
    .byte_select_out, .dma_request_n_in, .dma_enable_line_n_out,
    .memory_sense_bus_n_in, .mem_bus_out, .mem_bus_oe_out,
    .module_select_n_out, .module_addr_n_out, .module_addr_out,
    .protect_addr_out, .memory_busy_out, .mid_cycle_pulse_out,
    .cycle_complete_pulse_out
  );

  core_mem_model core_mem_model_inst
  (
    .clk_in(clk_in),
    .start_pulse_in(mid_cycle_pulse_out),
    .rd_data_in(rdata),
    .sense_n_out(memory_sense_bus_n_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_in = 1'b0;
    forever #(CLK_NS / 2) clk_in = ~clk_in;
  end

  // Generous bound: whole run is under two hundred cycles
  initial
  begin
    #(CLK_NS * 30000);
    err_total++;
    conclude();
  end

  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r[15:0];
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Datapath clock pulse; its falling edge acts one clock later
  task automatic dp(input logic hi, input logic [15:0] v);
    source_bus_in = v;
    if (hi)
      datapath_clock_high_in = 1'b1;
    else
      datapath_clock_low_in = 1'b1;
    cyc(1);
    datapath_clock_high_in = 1'b0;
    datapath_clock_low_in = 1'b0;
    cyc(2);
  endtask

  task automatic wait_start();
    int n;
    n = 0;
    while (mid_cycle_pulse_out !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    `CHK(n < 20, 1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (processor_busy_ind_out !== 1'b0 && n < 20)
    begin
      cyc(1);
      n++;
    end
    `CHK(n < 20, 1);
  endtask

  task automatic wait_grant();
    int n;
    n = 0;
    while (dma_enable_line_n_out === 4'hF && n < 20)
    begin
      cyc(1);
      n++;
    end
    `CHK(dma_enable_line_n_out, req_n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    checked = 0;
    lfsr_r = 32'h0001_1BDF;
    rst_in = 1'b1;
    {datapath_clock_low_in, datapath_clock_high_in} = 2'b00;
    {load_address_ctl_in, byte_swap_request_in} = 2'b00;
    {read_cycle_in, processor_mem_start_in} = 2'b00;
    source_bus_in = 16'h0000;
    rdata = 16'h0000;
    dma_request_n_in = 4'hF;
    exp_word = 0;
    cyc(3);
    rst_in = 1'b0;
    cyc(1);
    `CHK(dma_enable_line_n_out, 4'hF);
    `CHK({processor_busy_ind_out, mem_bus_oe_out}, 2'b00);
    // Address ranks, module decode and byte loads over all modules
    for (int m = 0; m < 8; m++)
    begin
      d = rnd();
      a = {m[2:0], d[11:0]};
      load_address_ctl_in = 1'b1;
      dp(1'b0, {1'b1, a});
      load_address_ctl_in = 1'b0;
      sel = ~(8'h01 << m);
      `CHK(addr_b_bus_out, {1'b0, a});
      `CHK(byte_select_out, {~a[0]});
      `CHK(module_select_n_out, sel);
      `CHK({module_addr_out, module_addr_n_out}, {a[14:12], ~a[14:12]});
      `CHK(protect_addr_out, a[14:8]);
      d = rnd();
      dp(1'b1, d);
      exp_word = d;
      `CHK(word_b_bus_out, exp_word);
      d = rnd();
      byte_swap_request_in = 1'b1;
      dp(1'b1, d);
      byte_swap_request_in = 1'b0;
      if (!a[0])
        exp_word[15:8] = d[7:0];
      else
        exp_word[7:0] = d[15:8];
      `CHK(word_b_bus_out, exp_word);
    end
    // Processor read; master moves while slave must hold
    rdata = rnd();
    read_cycle_in = 1'b1;
    processor_mem_start_in = 1'b1;
    wait_start();
    processor_mem_start_in = 1'b0;
    `CHK(mem_bus_oe_out, 1'b1);
    `CHK(mem_bus_out.addr_n, {~a});
    `CHK({mem_bus_out.read_n, data_unavailable_out}, 2'b01);
    `CHK(processor_busy_ind_out, 1'b1);
    d = rnd();
    load_address_ctl_in = 1'b1;
    dp(1'b0, d);
    load_address_ctl_in = 1'b0;
    `CHK(protect_addr_out, a[14:8]);
    wait_idle();
    read_cycle_in = 1'b0;
    cyc(2);
    `CHK(protect_addr_out, d[14:8]);
    `CHK(word_b_bus_out, rdata);
    // DMA ports; port 3 holds for two cycles, port 1 meets a cpu start
    for (int i = 3; i >= 0; i--)
    begin
      req_n = 4'hF;
      req_n[i] = 1'b0;
      dma_request_n_in = req_n;
      wait_grant();
      if (i != 3)
        dma_request_n_in = 4'hF;
      if (i == 1)
        processor_mem_start_in = 1'b1;
      `CHK(processor_busy_ind_out, 1'b1);
      wait_start();
      `CHK(mem_bus_oe_out, 1'b0);
      cyc(2);
      `CHK(cycle_complete_pulse_out, 1'b1);
      if (i == 3)
      begin
        wait_grant();
        dma_request_n_in = 4'hF;
        wait_start();
        `CHK(mem_bus_oe_out, 1'b0);
        cyc(1);
      end
      if (i == 1)
      begin
        wait_start();
        processor_mem_start_in = 1'b0;
        `CHK(mem_bus_oe_out, 1'b1);
        `CHK(mem_bus_out.data_n, {~rdata});
        `CHK({mem_bus_out.read_n, mem_bus_out.start_n}, 2'b10);
        cyc(1);
      end
      wait_idle();
      cyc(3);
      `CHK({dma_enable_line_n_out, memory_busy_out}, 5'h1E);
    end
    conclude();
  end
endmodule
